// ==== design/ssm_map.svh ====
// Purpose: shared constants for the string multiply sequencer
// Assumes: 24-bit words, 14-bit core memory address, 25 MHz system clock
// Notes: offsets are byte addresses on the plain register port
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

`define SSM_WORD_W 24
`define SSM_ADDR_W 14
`define SSM_OPC_HI 23
`define SSM_OPC_LO 18
`define SSM_IDX_HI 17
`define SSM_IDX_LO 15
`define SSM_OPA_HI 13
`define SSM_SIGN_BIT 23
`define SSM_OPC_MULTIPLY 6'h2D
`define SSM_IDX_NONE 3'h0
`define SSM_Q_CELL 14'h0008

`define SSM_SLOT_ADDR 3'h1
`define SSM_SLOT_WAIT 3'h2
`define SSM_SLOT_T3 3'h3
`define SSM_SLOT_T4 3'h4
`define SSM_SLOT_RELEASE 3'h5
`define SSM_SLOT_ENV6 3'h6

`define SSM_DTC_IDLE 5'h18
`define SSM_DTC_ARITH 5'h16
`define SSM_DTC_SHIFT 5'h17
`define SSM_J_PRESET 5'h07
`define SSM_J_DONE 5'h1F

`define SSM_CLK_PERIOD_NS 40
`define SSM_MEM_WINDOW_NS 1600
`define SSM_MEM_WINDOW_CYC ((`SSM_MEM_WINDOW_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)

`define SSM_REG_A 8'h00
`define SSM_REG_STATUS 8'h04
`define SSM_REG_B 8'h08
`define SSM_REG_IR 8'h0C
`define SSM_ST_MULDIV 0
`define SSM_ST_EXEC 1
`define SSM_ST_RUN 2
`define SSM_ST_OVF 3
`define SSM_ST_BUSY 4
`define SSM_ST_UNSUP 5

`endif

// ==== design/ssm_pkg.sv ====
// Purpose: types for the string multiply sequencer
// Assumes: constants come from ssm_map.svh
// Notes: states follow the instruction sequence states
package ssm_pkg;
    typedef enum logic [2:0] {
        SSM_IDLE,
        SSM_S1,
        SSM_S3,
        SSM_S4,
        SSM_S5
    } ssm_state_type;
endpackage

// ==== design/ssm_alu_if.sv ====
// Purpose: operand and result bundle between sequencer and adder
// Assumes: 24-bit two's complement words
// Notes: purely combinational signals
`timescale 1ns/10ps
`include "ssm_map.svh"
interface ssm_alu_if;
    logic [`SSM_WORD_W-1:0] opa;
    logic [`SSM_WORD_W-1:0] opb;
    logic sub;
    logic [`SSM_WORD_W-1:0] sum;
    logic ovf;
    modport user (output opa, output opb, output sub, input sum, input ovf);
    modport unit (input opa, input opb, input sub, output sum, output ovf);
endinterface

// ==== design/ssm_addsub.sv ====
// Purpose: 24-bit adder/subtractor with signed overflow
// Assumes: operands are two's complement
// Notes: combinational; the sequencer decides when the result is used
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_addsub (
    ssm_alu_if.unit alu // operand and result bundle
);
    logic [`SSM_WORD_W-1:0] opb_eff;
    logic [`SSM_WORD_W:0] wide;

    // subtract as add of the complement plus one
    assign opb_eff = alu.sub ? ~alu.opb : alu.opb;
    assign wide = {1'b0, alu.opa} + {1'b0, opb_eff} + {{`SSM_WORD_W{1'b0}}, alu.sub};
    assign alu.sum = wide[`SSM_WORD_W-1:0];
    // overflow when operand signs agree and the result sign differs
    assign alu.ovf = (alu.opa[`SSM_SIGN_BIT] == opb_eff[`SSM_SIGN_BIT]) &&
                     (alu.sum[`SSM_SIGN_BIT] != alu.opa[`SSM_SIGN_BIT]);
endmodule

// ==== design/ssm_sequencer.sv ====
// Purpose: sequencing and datapath of the string-recoded signed multiply
// Assumes: core memory answers each request with one ready pulse
// Notes: non-multiply or indexed instructions end after state 1 as unsupported
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_sequencer (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_b_in, // synchronous reset, active low
    input wire logic start_in, // begin an instruction at pc_in
    input wire logic [`SSM_ADDR_W-1:0] pc_in, // instruction address
    output logic mem_req_out, // memory request pulse
    output logic mem_we_out, // request is a write
    output logic [`SSM_ADDR_W-1:0] mem_addr_out, // memory address
    output logic [`SSM_WORD_W-1:0] mem_wdata_out, // memory write data
    input wire logic [`SSM_WORD_W-1:0] mem_rdata_in, // memory read data
    input wire logic mem_ready_in, // memory answer pulse
    input wire logic [7:0] reg_addr_in, // register byte address
    input wire logic [31:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in, // register write strobe
    input wire logic reg_rd_in, // register read strobe
    output logic [31:0] reg_rdata_out, // register read data
    output logic muldiv_active_flag_out, // multiply/divide flag, set in state 3, held until the next state 1
    output logic execute_phase_flag_out, // execute flag
    output logic run_of_ones_flag_out, // inside a run of ones
    output logic overflow_flag_out, // sticky overflow
    output logic busy_out, // sequence running
    output logic done_out // instruction finished pulse
);
    ssm_pkg::ssm_state_type state;
    logic [2:0] slot;
    logic [4:0] dtc, jcnt;
    logic [5:0] win_cnt;
    logic [`SSM_ADDR_W-1:0] pc;
    logic [`SSM_WORD_W-1:0] a_reg, b_reg, ir;
    logic fixup, ofl_corr, unsupported;
    logic muldiv_active_flag, execute_phase_flag, run_of_ones_flag, overflow_flag;
    logic is_multiply, in_loop, bit_count_done, step_add, step_sub, fix_add, fix_sub;
    logic do_arith, shift_pair_right, last_pulse_enable, win_done, mem_taken;
    ssm_alu_if alu ();
    ssm_addsub u_addsub (.alu(alu));

    assign is_multiply = (ir[`SSM_OPC_HI:`SSM_OPC_LO] == `SSM_OPC_MULTIPLY) &&
                         (ir[`SSM_IDX_HI:`SSM_IDX_LO] == `SSM_IDX_NONE);
    assign in_loop = (state == ssm_pkg::SSM_S4) && (slot == `SSM_SLOT_ENV6);
    assign bit_count_done = (jcnt == `SSM_J_DONE);
    assign mem_taken = (slot == `SSM_SLOT_WAIT) && mem_ready_in;
    assign win_done = (win_cnt >= 6'(`SSM_MEM_WINDOW_CYC - 1));

    // string recoding: low two multiplier bits plus run flag
    always_comb begin
        step_add = 1'b0;
        step_sub = 1'b0;
        if (!run_of_ones_flag) begin
            step_add = (b_reg[1:0] == 2'h1);
            step_sub = (b_reg[1:0] == 2'h3);
        end else begin
            step_add = (b_reg[1:0] == 2'h0);
            step_sub = (b_reg[1:0] == 2'h2);
        end
    end

    // fix-up against the multiplier sign left in B23
    assign fix_add = !b_reg[`SSM_SIGN_BIT] && run_of_ones_flag;
    assign fix_sub = b_reg[`SSM_SIGN_BIT] && !run_of_ones_flag;

    assign do_arith = in_loop && (dtc == `SSM_DTC_ARITH);
    assign shift_pair_right = in_loop && !fixup &&
        ((dtc == `SSM_DTC_SHIFT) ||
         ((dtc == `SSM_DTC_IDLE) && !bit_count_done && !step_add && !step_sub));
    // the fix-up step ends the state without a shift
    assign last_pulse_enable = in_loop &&
        (((dtc == `SSM_DTC_SHIFT) && fixup) ||
         ((dtc == `SSM_DTC_IDLE) && bit_count_done && !fix_add && !fix_sub));

    // state 3 passes B through the adder alone; state 4 combines A with IR
    always_comb begin
        if (state == ssm_pkg::SSM_S3) begin
            alu.opa = {`SSM_WORD_W{1'b0}};
            alu.opb = b_reg;
            alu.sub = 1'b0;
        end else begin
            alu.opa = a_reg;
            alu.opb = ir;
            alu.sub = fixup ? fix_sub : step_sub;
        end
    end

    // sequence states and time slots
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state <= ssm_pkg::SSM_IDLE;
            slot <= `SSM_SLOT_ADDR;
        end else begin
            case (state)
                ssm_pkg::SSM_IDLE: begin
                    if (start_in) begin
                        state <= ssm_pkg::SSM_S1;
                        slot <= `SSM_SLOT_ADDR;
                    end
                end
                ssm_pkg::SSM_S1, ssm_pkg::SSM_S3: begin
                    if (slot == `SSM_SLOT_ADDR) begin
                        slot <= `SSM_SLOT_WAIT;
                    end else if (slot == `SSM_SLOT_WAIT) begin
                        if (mem_ready_in) begin
                            slot <= `SSM_SLOT_T3;
                        end
                    end else if (slot == `SSM_SLOT_RELEASE) begin
                        slot <= `SSM_SLOT_ADDR;
                        if (state == ssm_pkg::SSM_S3) begin
                            state <= ssm_pkg::SSM_S4;
                        end else if (is_multiply) begin
                            state <= ssm_pkg::SSM_S3;
                        end else begin
                            state <= ssm_pkg::SSM_IDLE;
                        end
                    end else begin
                        slot <= slot + 3'h1;
                    end
                end
                ssm_pkg::SSM_S4: begin
                    if (slot == `SSM_SLOT_ADDR) begin
                        slot <= `SSM_SLOT_WAIT;
                    end else if (slot == `SSM_SLOT_WAIT) begin
                        if (mem_ready_in) begin
                            slot <= `SSM_SLOT_T3;
                        end
                    end else if (slot == `SSM_SLOT_RELEASE) begin
                        if (win_done) begin
                            slot <= `SSM_SLOT_ENV6;
                        end
                    end else if (slot == `SSM_SLOT_ENV6) begin
                        if (last_pulse_enable) begin
                            state <= ssm_pkg::SSM_S5;
                            slot <= `SSM_SLOT_ADDR;
                        end
                    end else begin
                        slot <= slot + 3'h1;
                    end
                end
                ssm_pkg::SSM_S5: begin
                    if (slot == `SSM_SLOT_ADDR) begin
                        slot <= `SSM_SLOT_WAIT;
                    end else if (mem_ready_in) begin
                        state <= ssm_pkg::SSM_IDLE;
                        slot <= `SSM_SLOT_ADDR;
                    end
                end
                default: begin
                    state <= ssm_pkg::SSM_IDLE;
                    slot <= `SSM_SLOT_ADDR;
                end
            endcase
        end
    end

    // memory window timer, only counts while in state 4
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            win_cnt <= 6'h00;
        end else if (state != ssm_pkg::SSM_S4) begin
            win_cnt <= 6'h00;
        end else if (!win_done) begin
            win_cnt <= win_cnt + 6'h01;
        end
    end

    // delay-time counter, bit counter and fix-up marker
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            dtc <= `SSM_DTC_IDLE;
            jcnt <= `SSM_J_PRESET;
            fixup <= 1'b0;
        end else if ((state == ssm_pkg::SSM_S4) && (slot == `SSM_SLOT_T3)) begin
            dtc <= `SSM_DTC_IDLE;
            jcnt <= `SSM_J_PRESET;
            fixup <= 1'b0;
        end else if ((state == ssm_pkg::SSM_S4) && (slot == `SSM_SLOT_RELEASE) && win_done) begin
            jcnt <= jcnt + 5'h01;
        end else if (in_loop) begin
            case (dtc)
                `SSM_DTC_IDLE: begin
                    if (!bit_count_done) begin
                        if (step_add || step_sub) begin
                            dtc <= `SSM_DTC_ARITH;
                        end else begin
                            jcnt <= jcnt + 5'h01;
                        end
                    end else if (fix_add || fix_sub) begin
                        dtc <= `SSM_DTC_ARITH;
                        fixup <= 1'b1;
                    end
                end
                `SSM_DTC_ARITH: dtc <= `SSM_DTC_SHIFT;
                `SSM_DTC_SHIFT: begin
                    dtc <= `SSM_DTC_IDLE;
                    if (fixup) begin
                        fixup <= 1'b0;
                    end else begin
                        jcnt <= jcnt + 5'h01;
                    end
                end
                default: dtc <= `SSM_DTC_IDLE;
            endcase
        end
    end

    // A register: software load while idle, sum at arith, shift after
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            a_reg <= {`SSM_WORD_W{1'b0}};
        end else if ((state == ssm_pkg::SSM_IDLE) && reg_wr_in && (reg_addr_in == `SSM_REG_A)) begin
            a_reg <= reg_wdata_in[`SSM_WORD_W-1:0];
        end else if (do_arith) begin
            a_reg <= alu.sum;
        end else if (shift_pair_right) begin
            // true sign is inverted when the last sum overflowed
            a_reg <= {a_reg[`SSM_SIGN_BIT] ^ ofl_corr,
                      a_reg[`SSM_SIGN_BIT:1]};
        end
    end

    // overflow correction marker for the next shift
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ofl_corr <= 1'b0;
        end else if (do_arith) begin
            ofl_corr <= alu.ovf;
        end else if (shift_pair_right || (state == ssm_pkg::SSM_S3)) begin
            ofl_corr <= 1'b0;
        end
    end

    // B register: operands from memory, pair shift, sign clear in state 5
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            b_reg <= {`SSM_WORD_W{1'b0}};
        end else if (mem_taken && ((state == ssm_pkg::SSM_S3) || (state == ssm_pkg::SSM_S4))) begin
            b_reg <= mem_rdata_in;
        end else if (shift_pair_right) begin
            // multiplier sign stays in B23 for the fix-up decision
            b_reg <= {b_reg[`SSM_SIGN_BIT], a_reg[0],
                      b_reg[`SSM_SIGN_BIT-1:1]};
        end else if ((state == ssm_pkg::SSM_S5) && (slot == `SSM_SLOT_ADDR)) begin
            b_reg[`SSM_SIGN_BIT] <= 1'b0;
        end
    end

    // instruction register: fetched word, later the multiplicand
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ir <= {`SSM_WORD_W{1'b0}};
        end else if (mem_taken && (state == ssm_pkg::SSM_S1)) begin
            ir <= mem_rdata_in;
        end else if ((state == ssm_pkg::SSM_S3) && (slot == `SSM_SLOT_T4)) begin
            ir <= alu.sum;
        end
    end

    // sequencing flags; reset clears them all
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            muldiv_active_flag <= 1'b0;
            execute_phase_flag <= 1'b0;
        end else if ((state == ssm_pkg::SSM_S1) && (slot == `SSM_SLOT_ADDR)) begin
            muldiv_active_flag <= 1'b0;
        end else if ((state == ssm_pkg::SSM_S3) && (slot == `SSM_SLOT_T3)) begin
            muldiv_active_flag <= 1'b1;
            execute_phase_flag <= 1'b0;
        end
    end

    // run-of-ones flag clears at state 4 slot 3, then changes only with the pair shift
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            run_of_ones_flag <= 1'b0;
        end else if ((state == ssm_pkg::SSM_S4) && (slot == `SSM_SLOT_T3)) begin
            run_of_ones_flag <= 1'b0;
        end else if (shift_pair_right) begin
            if (!run_of_ones_flag && (b_reg[1:0] == 2'h3)) begin
                run_of_ones_flag <= 1'b1;
            end else if (run_of_ones_flag && (b_reg[1:0] == 2'h0)) begin
                run_of_ones_flag <= 1'b0;
            end
        end
    end

    // sticky overflow; a fix-up overflow wins over a software clear
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            overflow_flag <= 1'b0;
        end else if (in_loop && fixup && (dtc == `SSM_DTC_SHIFT) && ofl_corr) begin
            overflow_flag <= 1'b1;
        end else if (reg_wr_in && (reg_addr_in == `SSM_REG_STATUS) &&
                     reg_wdata_in[`SSM_ST_OVF]) begin
            overflow_flag <= 1'b0;
        end
    end

    // unsupported instruction marker and done pulse
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            unsupported <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if ((state == ssm_pkg::SSM_S1) && (slot == `SSM_SLOT_RELEASE)) begin
                unsupported <= !is_multiply;
                done_out <= !is_multiply;
            end else if ((state == ssm_pkg::SSM_S5) && mem_taken) begin
                done_out <= 1'b1;
            end
        end
    end

    // memory port: one request pulse per state, write flag, address and data held until the next
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pc <= {`SSM_ADDR_W{1'b0}};
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= {`SSM_ADDR_W{1'b0}};
            mem_wdata_out <= {`SSM_WORD_W{1'b0}};
        end else begin
            mem_req_out <= 1'b0;
            if ((state == ssm_pkg::SSM_IDLE) && start_in) begin
                pc <= pc_in;
            end
            // idle also sits in the address slot but makes no request
            if ((slot == `SSM_SLOT_ADDR) && (state != ssm_pkg::SSM_IDLE)) begin
                mem_req_out <= 1'b1;
                mem_we_out <= (state == ssm_pkg::SSM_S5);
                case (state)
                    ssm_pkg::SSM_S1: mem_addr_out <= pc;
                    ssm_pkg::SSM_S3: mem_addr_out <= ir[`SSM_OPA_HI:0];
                    default: mem_addr_out <= `SSM_Q_CELL;
                endcase
                mem_wdata_out <= {1'b0, b_reg[`SSM_SIGN_BIT-1:0]};
            end
        end
    end

    // register read port; data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `SSM_REG_A: reg_rdata_out <= {8'h00, a_reg};
                `SSM_REG_B: reg_rdata_out <= {8'h00, b_reg};
                `SSM_REG_IR: reg_rdata_out <= {8'h00, ir};
                `SSM_REG_STATUS: reg_rdata_out <= {26'h0, unsupported, busy_out, overflow_flag,
                    run_of_ones_flag, execute_phase_flag, muldiv_active_flag};
                default: reg_rdata_out <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    assign busy_out = (state != ssm_pkg::SSM_IDLE);
    assign muldiv_active_flag_out = muldiv_active_flag;
    assign execute_phase_flag_out = execute_phase_flag;
    assign run_of_ones_flag_out = run_of_ones_flag;
    assign overflow_flag_out = overflow_flag;
endmodule

// ==== verification/ssm_sequencer_assertions.sv ====
// Purpose: port assertions for the string multiply sequencer
// Assumes: instruction and operand cells never sit at the Q cell
// Notes: bound onto every ssm_sequencer instance
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_sequencer_assertions (
    input wire logic clk_sys_in, // clock
    input wire logic rst_b_in, // reset
    input wire logic mem_req_out, // request
    input wire logic mem_we_out, // write
    input wire logic [`SSM_ADDR_W-1:0] mem_addr_out, // address
    input wire logic [`SSM_WORD_W-1:0] mem_wdata_out, // write data
    input wire logic muldiv_active_flag_out, // muldiv flag
    input wire logic execute_phase_flag_out, // execute flag
    input wire logic overflow_flag_out, // overflow
    input wire logic busy_out, // busy
    input wire logic done_out // done
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    wire q_rd = mem_req_out && !mem_we_out && mem_addr_out == `SSM_Q_CELL;
    wire q_wr = mem_req_out && mem_we_out;
    AST_QREAD_FLAG: assert property (q_rd |-> muldiv_active_flag_out)
        else $error("muldiv low at multiplier fetch");
    AST_NO_EXEC: assert property (!execute_phase_flag_out)
        else $error("execute flag set");
    AST_LOOP_SPAN: assert property (q_rd |-> ##[60:220] q_wr)
        else $error("store outside loop span");
    AST_Q_STORE: assert property (q_wr |-> mem_addr_out == `SSM_Q_CELL && !mem_wdata_out[23])
        else $error("bad product store");
    AST_STORE_DONE: assert property (q_wr |-> ##[1:20] done_out)
        else $error("no done after store");
    AST_REQ_PULSE: assert property (mem_req_out |=> !mem_req_out)
        else $error("request longer than a cycle");
    AST_RESET: assert property (disable iff (1'b0) !rst_b_in |=> !muldiv_active_flag_out && !busy_out)
        else $error("reset left sequencer active");
    AST_OVF_SEQ: assert property ($rose(overflow_flag_out) |-> busy_out && muldiv_active_flag_out)
        else $error("overflow outside multiply");
endmodule
bind ssm_sequencer ssm_sequencer_assertions ssm_sequencer_assertions_i (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .busy_out(busy_out),
    .muldiv_active_flag_out(muldiv_active_flag_out), .done_out(done_out),
    .execute_phase_flag_out(execute_phase_flag_out), .overflow_flag_out(overflow_flag_out));

// ==== verification/ssm_mem_model.sv ====
// Purpose: core memory stand-in for the sequencer
// Assumes: one request outstanding at a time
// Notes: read data scrambled outside the answer cycle
`timescale 1ns/10ps
module ssm_mem_model (
    input wire logic clk_sys_in, // clock
    input wire logic req_in, // request
    input wire logic we_in, // write
    input wire logic [13:0] addr_in, // address
    input wire logic [23:0] wdata_in, // write data
    input wire logic [3:0] lat_in, // answer delay
    output logic [23:0] rdata_out = 24'h0, // read data
    output logic ready_out = 1'h0 // answer pulse
);
    logic [23:0] mem [0:16383];
    logic [3:0] cnt = 4'h0;
    always @(posedge clk_sys_in) begin
        ready_out <= cnt == 4'h1;
        rdata_out <= cnt == 4'h1 ? mem[addr_in] : ~rdata_out;
        cnt <= req_in ? lat_in : cnt - 4'(cnt != 4'h0);
        if (req_in && we_in) mem[addr_in] <= wdata_in;
    end
endmodule

// ==== verification/tb.sv ====
// Purpose: directed multiply tests for the string multiply sequencer
// Assumes: memory answers through ssm_mem_model
// Notes: products are worked out here in 48-bit signed arithmetic
`timescale 1ns/10ps
`include "ssm_map.svh"
module tb;
    logic clk_sys_in = 1'h0, rst_b_in = 1'h0, start_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
    logic [13:0] pc_in = 14'h0;
    logic [7:0] reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0, rdata;
    logic [3:0] lat = 4'h1;
    logic mreq, mwe, mrdy, muldiv, exe, run, ovf, busy, done;
    logic [13:0] maddr;
    logic [23:0] mwd, mrd;
    logic [23:0] tq [0:5] = '{24'h00000C, 24'hFFFFFB, 24'h7FFFFF, 24'hAAAAAA, 24'h800000, 24'h800000};
    logic [23:0] tz [0:5] = '{24'h00000F, 24'h000007, 24'h7FFFFF, 24'h555555, 24'h800000, 24'h800000};
    logic [23:0] ta [0:5] = '{24'h0, 24'h000003, 24'hFFFFFF, 24'h400000, 24'h0, 24'hFFFFFF};
    int n_mismatch = 0;
    int samples_checked = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    ssm_sequencer ssm_sequencer_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .start_in(start_in), .pc_in(pc_in), .mem_req_out(mreq), .mem_we_out(mwe),
        .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_rdata_in(mrd), .mem_ready_in(mrdy),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .muldiv_active_flag_out(muldiv),
        .execute_phase_flag_out(exe), .run_of_ones_flag_out(run), .overflow_flag_out(ovf),
        .busy_out(busy), .done_out(done));
    ssm_mem_model ssm_mem_model_i (.clk_sys_in(clk_sys_in), .req_in(mreq), .we_in(mwe),
        .addr_in(maddr), .wdata_in(mwd), .lat_in(lat), .rdata_out(mrd), .ready_out(mrdy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'h0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'h0;
        #1 chk(rdata, exp);
        @(posedge clk_sys_in);
    endtask
    task automatic go(input logic [13:0] pc);
        start_in <= 1'h1;
        pc_in <= pc;
        @(posedge clk_sys_in);
        start_in <= 1'h0;
        #1;
        for (int i = 0; i < 400 && done !== 1'h1; i++) @(posedge clk_sys_in) #1;
        chk({31'h0, done}, 32'h1);
        @(posedge clk_sys_in);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        logic signed [47:0] p;
        repeat (8) @(posedge clk_sys_in);
        rst_b_in <= 1'h1;
        @(posedge clk_sys_in);
        rd(8'h40, 32'h0);
        for (int k = 0; k < 6; k++) begin
            ssm_mem_model_i.mem[14'h0100 + k] = {6'h2D, 4'h0, 14'h0200 + 14'(k)};
            ssm_mem_model_i.mem[14'h0200 + k] = tz[k];
            ssm_mem_model_i.mem[`SSM_Q_CELL] = tq[k];
            lat <= k[0] ? 4'h6 : 4'h1;
            wr(`SSM_REG_A, {8'h0, ta[k]});
            go(14'h0100 + 14'(k));
            p = $signed(tz[k]) * $signed(tq[k]) + $signed(ta[k]);
            chk(ssm_mem_model_i.mem[`SSM_Q_CELL], {1'h0, p[22:0]});
            rd(`SSM_REG_B, {9'h0, p[22:0]});
            rd(`SSM_REG_A, {8'h0, p[46:23]});
            rd(`SSM_REG_IR, {8'h0, tz[k]});
            chk(ovf, k == 4);
            chk({muldiv, exe}, 2'h2);
            wr(`SSM_REG_STATUS, 32'h8);
            $display("multiply test %0d done", k);
        end
        ssm_mem_model_i.mem[14'h0180] = 24'h0;
        go(14'h0180);
        chk(muldiv, 1'h0);
        rd(`SSM_REG_STATUS, 32'h20);
        $display("follow-on test done");
        go(14'h0100);
        start_in <= 1'h1;
        @(posedge clk_sys_in);
        start_in <= 1'h0;
        repeat (60) @(posedge clk_sys_in);
        #1 chk(muldiv, 1'h1);
        @(posedge clk_sys_in);
        rst_b_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        #1 chk({run, muldiv, busy}, 3'h0);
        $display("reset test done");
        close_out;
    end
    initial begin
        repeat (6000) @(posedge clk_sys_in);
        n_mismatch++;
        close_out;
    end
endmodule
